/* File: msadc_afe_model.sv */
// Purpose: Behavioural model of the integrator, comparators and bridge detector.
// Assumes: Comparator outputs are always driven, low when their slope is not active, except zero-cross during charge with overrange_i.
// Notes:   Slope lengths are random, so the slow-level flag comes before or after the fast discharge minimum.
`default_nettype none
module msadc_afe_model (
   input  wire logic                     mclk_i,
   input  wire logic                     rst_i,
   input  wire msadc_pkg::afe_ctrl_type  ctrl_i,
   input  wire logic                     unbalanced_i,
   input  wire logic                     overrange_i,
   output var  msadc_pkg::afe_flags_type flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================================
   // Slope timing
   // ======================================================================
   logic [2:0]  phase_reg = '0;
   logic [2:0]  phase;
   int unsigned cnt = 0;
   int unsigned target = 0;
   assign phase = {ctrl_i.charge_enable, !ctrl_i.fast_discharge_n, !ctrl_i.slow_discharge_n};
   // A new target is drawn on every phase change, since a real slope varies with input.
   always @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_o <= 4'b0001;
         phase_reg <= '0;
         cnt = 0;
      end else begin
         if (phase != phase_reg) begin
            cnt = 0;
            if (phase[2]) target = $urandom_range(1000, 50);
            else if (phase[1]) target = $urandom_range(4000, 1500);
            else target = $urandom_range(1000, 10);
         end
         cnt++;
         phase_reg <= phase;
         flags_o.charge_threshold_flag <= phase[2] && cnt >= target;
         flags_o.slow_level_flag <= phase[1] && cnt >= target;
         flags_o.zero_cross_flag <= (phase[0] && cnt >= target) || (phase[2] && overrange_i);
         flags_o.bridge_unbalanced_n <= !unbalanced_i;
      end
   end
endmodule
`default_nettype wire

/* File: msadc_defines.svh */
// Purpose: Timing constants and field layouts for the multi-slope converter sequencer.
// Assumes: System clock mclk_i at 50 MHz.
// Notes:   Times are kept in their own unit; cycle counts are derived from them.
`ifndef MSADC_DEFINES_SVH
`define MSADC_DEFINES_SVH

// ==========================================================================
// Clock and times
// ==========================================================================
`define CLK_HZ            50000000
`define SYNC_US           50
`define INTEGRATOR_RESET_DELAY_US     100
`define INTEGRATOR_RESET_LOW_US       500
`define HOLD_US           20
`define FAST_MIN_US       512
`define INTERIM_US        2000
`define CHARGE_US         10000
`define SYNC_CYC          ((`SYNC_US * (`CLK_HZ / 1000000)))
`define INTEGRATOR_RESET_DELAY_CYC    ((`INTEGRATOR_RESET_DELAY_US * (`CLK_HZ / 1000000)))
`define INTEGRATOR_RESET_LOW_CYC      ((`INTEGRATOR_RESET_LOW_US * (`CLK_HZ / 1000000)))
`define HOLD_CYC          ((`HOLD_US * (`CLK_HZ / 1000000)))
`define FAST_MIN_CYC      ((`FAST_MIN_US * (`CLK_HZ / 1000000)))
`define INTERIM_CYC       ((`INTERIM_US * (`CLK_HZ / 1000000)))
`define CHARGE_CYC        ((`CHARGE_US * (`CLK_HZ / 1000000)))
// A 4 MHz count tick is made from the 50 MHz clock by a fractional accumulator.
`define TICK_HZ           4000000
`define ACC_W             26
// Mode encodings, cycle figures and counter widths.
`define MODE_HIGH_SPEED   2'h0
`define MODE_NORMAL       2'h1
`define MODE_AVERAGE      2'h2
`define CYCLES_PER_MEAS   3'h5
`define SHIFT_CYCLE       3'h2
`define FAST_W            12
`define SLOW_W            7
`define TIMER_W           26
`endif

/* File: msadc_pkg.sv */
// Purpose: Types shared by the converter sequencer.
// Assumes: Field widths are written out by hand to match msadc_defines.svh.
// Notes:   Holds state enumeration and packed carriers.
`default_nettype none
package msadc_pkg;
   // Sequencer states with binary codes written out.
   typedef enum logic [3:0] {
      st_idle     = 4'b0000,
      st_sync     = 4'b0001,
      st_integrator_reset_dly = 4'b0010,
      st_hold1    = 4'b0011,
      st_charge   = 4'b0100,
      st_hold_a   = 4'b0101,
      st_fast     = 4'b0110,
      st_hold_b   = 4'b0111,
      st_slow     = 4'b1000,
      st_integrator_reset_low = 4'b1001,
      st_interim  = 4'b1010,
      st_hold2    = 4'b1011
   } seq_state_type;

   // Flags from the analog front end.
   typedef struct packed {
      logic charge_threshold_flag;
      logic slow_level_flag;
      logic zero_cross_flag;
      logic bridge_unbalanced_n;
   } afe_flags_type;

   // Controls toward the analog front end.
   typedef struct packed {
      logic phase_sync;
      logic integrator_reset;
      logic charge_enable;
      logic fast_discharge_n;
      logic slow_discharge_n;
      logic hold1;
      logic hold2;
      logic quadrature_shift;
      logic vector_select_a;
      logic vector_select_b;
      logic count_gate;
   } afe_ctrl_type;

   // Sequencer state; only the balance strobe register lies outside it.
   typedef struct packed {
      seq_state_type     state;
      logic [25:0]       timer;
      logic [2:0]        cycle;
      logic [1:0]        cycle_mode;
      logic [25:0]       acc;
      logic [11:0]       fast_cnt;
      logic [6:0]        slow_cnt;
      logic [11:0]       result_fast;
      logic [6:0]        result_slow;
      afe_ctrl_type      ctrl;
      logic              conversion_done;
      logic              unbalanced_indication;
      logic              overrange_detect;
      logic              busy;
      logic [1:0]        bal_sync;
      logic [5:0]        flag_sync;
   } seq_type;
endpackage
`default_nettype wire

/* File: msadc_sequencer.sv */
// Purpose: Sequencer that drives a multi-slope integrating converter through a measurement.
// Assumes: 50 MHz mclk_i, asynchronous active-high rst_i, front-end flags asynchronous.
// Notes:   An offset cycle, redone while the bridge is unbalanced, then four vector cycles; counts are read on conversion_done_o.
`include "msadc_defines.svh"
`default_nettype none
module msadc_sequencer #(
   parameter int unsigned CHARGE_CYC = `CHARGE_CYC,
   parameter int unsigned INTERIM_CYC = `INTERIM_CYC,
   parameter int unsigned FAST_MIN_CYC = `FAST_MIN_CYC
) (
   input  wire logic                  mclk_i,
   input  wire logic                  rst_i,
   input  wire logic                  trigger_i,
   input  wire logic [1:0]            mode_i,
   input  wire msadc_pkg::afe_flags_type flags_i,
   output logic                       balance_check_strobe_o,
   output msadc_pkg::afe_ctrl_type    ctrl_o,
   output logic [11:0]                result_fast_o,
   output logic [6:0]                 result_slow_o,
   output logic [2:0]                 result_cycle_o,
   output logic                       conversion_done_o,
   output logic                       unbalanced_indication_o,
   output logic                       overrange_detect_o,
   output logic                       busy_o
);
   msadc_pkg::seq_type s_reg;
   msadc_pkg::seq_type s_next;
   logic thr_f, slow_f, zero_f, bal_f, tick;
   logic balance_strobe_next;
   logic balance_strobe_reg;

   // Synchronised flags: second stage of each synchroniser only.
   assign thr_f  = s_reg.flag_sync[3];
   assign slow_f = s_reg.flag_sync[4];
   assign zero_f = s_reg.flag_sync[5];
   assign bal_f  = s_reg.bal_sync[1];
   // The 4 MHz tick is an accumulator carry, so the average rate is exact.
   assign tick   = ({1'b0, s_reg.acc} + `ACC_W'(`TICK_HZ)) >= 27'(`CLK_HZ);

   // ==========================================================================
   // Next-state logic
   // ==========================================================================
   always_comb begin
      s_next = s_reg;
      s_next.flag_sync = {s_reg.flag_sync[2:0], flags_i.zero_cross_flag,
                          flags_i.slow_level_flag, flags_i.charge_threshold_flag};
      s_next.bal_sync = {s_reg.bal_sync[0], flags_i.bridge_unbalanced_n};
      s_next.conversion_done = 1'b0;
      s_next.timer = s_reg.timer + 26'h000_0001;
      s_next.acc = tick ? 26'(s_reg.acc + `TICK_HZ - `CLK_HZ)
                        : 26'(s_reg.acc + `TICK_HZ);
      s_next.ctrl.hold1 = 1'b0;
      s_next.ctrl.hold2 = 1'b0;
      unique case (s_reg.state)
         msadc_pkg::st_idle: begin
            s_next.busy = 1'b0;
            if (trigger_i) begin
               s_next.state = msadc_pkg::st_sync;
               s_next.cycle = 3'h0; // Offset cycle first.
               s_next.cycle_mode = mode_i;
               s_next.busy = 1'b1;
               s_next.overrange_detect = 1'b0;
               s_next.unbalanced_indication = 1'b0;
               s_next.ctrl.quadrature_shift = 1'b0;
               s_next.ctrl.phase_sync = 1'b1;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_sync: begin
            if (s_reg.timer == 26'(`SYNC_CYC - 1)) begin
               s_next.ctrl.phase_sync = 1'b0;
               s_next.state = msadc_pkg::st_integrator_reset_dly;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_integrator_reset_dly: begin
            if (s_reg.timer == 26'(`INTEGRATOR_RESET_DELAY_CYC - 1)) begin
               s_next.ctrl.integrator_reset = 1'b1;
               s_next.state = msadc_pkg::st_hold1;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_hold1, msadc_pkg::st_hold2: begin
            // Input switch opened while the selector settles.
            s_next.ctrl.hold1 = (s_reg.state == msadc_pkg::st_hold1);
            s_next.ctrl.hold2 = (s_reg.state == msadc_pkg::st_hold2);
            if (s_reg.timer == 26'(`HOLD_CYC - 1)) begin
               s_next.ctrl.hold1 = 1'b0;
               s_next.ctrl.hold2 = 1'b0;
               s_next.ctrl.charge_enable = 1'b1;
               s_next.state = msadc_pkg::st_charge;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_charge: begin
            if (zero_f) begin
               // Zero crossing while charging means the input saturated.
               s_next.overrange_detect = 1'b1;
               s_next.ctrl = '0;
               s_next.ctrl.fast_discharge_n = 1'b1;
               s_next.ctrl.slow_discharge_n = 1'b1;
               s_next.state = msadc_pkg::st_idle;
            end else if (thr_f || s_reg.timer == 26'(CHARGE_CYC - 1)) begin // Cap bounds run.
               s_next.ctrl.charge_enable = 1'b0;
               if (s_reg.cycle == `SHIFT_CYCLE)
                  s_next.ctrl.quadrature_shift = 1'b1;
               s_next.state = msadc_pkg::st_hold_a;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_hold_a: begin
            if (s_reg.timer == 26'(`HOLD_CYC - 1)) begin
               s_next.ctrl.fast_discharge_n = 1'b0;
               s_next.ctrl.count_gate = 1'b1;
               s_next.fast_cnt = 12'h000;
               s_next.slow_cnt = 7'h00;
               s_next.state = msadc_pkg::st_fast;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_fast: begin
            if (tick)
               s_next.fast_cnt = s_reg.fast_cnt + 12'h001;
            if (slow_f && s_reg.timer >= 26'(FAST_MIN_CYC - 1)) begin
               s_next.ctrl.fast_discharge_n = 1'b1;
               s_next.ctrl.count_gate = 1'b0;
               s_next.state = msadc_pkg::st_hold_b;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_hold_b: begin
            if (s_reg.timer == 26'(`HOLD_CYC - 1)) begin
               s_next.ctrl.slow_discharge_n = 1'b0;
               s_next.ctrl.count_gate = 1'b1;
               s_next.state = msadc_pkg::st_slow;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_slow: begin
            if (tick) begin
               s_next.slow_cnt = s_reg.slow_cnt + 7'h01;
               if (s_reg.slow_cnt == 7'h7F)
                  s_next.fast_cnt = s_reg.fast_cnt + 12'h001; // Carry.
            end
            if (zero_f) begin
               s_next.ctrl.slow_discharge_n = 1'b1;
               s_next.ctrl.count_gate = 1'b0;
               s_next.result_fast = s_next.fast_cnt;
               s_next.result_slow = s_next.slow_cnt;
               s_next.conversion_done = 1'b1;
               s_next.timer = 26'h000_0000;
               if (s_reg.cycle == 3'h0) begin
                  if (!bal_f) begin
                     // Bridge unbalanced: redo only the offset cycle.
                     s_next.unbalanced_indication = 1'b1;
                     s_next.state = msadc_pkg::st_interim;
                  end else begin
                     s_next.unbalanced_indication = 1'b0;
                     s_next.ctrl.integrator_reset = 1'b0;
                     s_next.state = msadc_pkg::st_integrator_reset_low;
                  end
               end else begin
                  s_next.cycle = s_reg.cycle + 3'h1;
                  s_next.state = msadc_pkg::st_interim;
               end
            end
         end
         msadc_pkg::st_integrator_reset_low: begin
            if (s_reg.timer == 26'(`INTEGRATOR_RESET_LOW_CYC - 1)) begin
               s_next.ctrl.integrator_reset = 1'b1;
               s_next.cycle = 3'h1;
               s_next.state = msadc_pkg::st_interim;
               s_next.timer = 26'h000_0000;
            end
         end
         msadc_pkg::st_interim: begin
            if (s_reg.timer == 26'(INTERIM_CYC - 1)) begin
               s_next.timer = 26'h000_0000;
               if (s_reg.cycle == `CYCLES_PER_MEAS) begin
                  s_next.state = msadc_pkg::st_idle;
                  s_next.busy = 1'b0;
               end else begin
                  // Vector 1,3 pick the unknown; 2,4 the reference.
                  s_next.ctrl.vector_select_a = s_reg.cycle[0];
                  s_next.ctrl.vector_select_b = ~s_reg.cycle[0] & (s_reg.cycle != 3'h0);
                  s_next.state = msadc_pkg::st_hold2;
               end
            end
         end
         default: s_next.state = msadc_pkg::st_idle;
      endcase
      // Strobe marks where the bridge is sampled, at the end of offset slow discharge.
      balance_strobe_next = (s_reg.state == msadc_pkg::st_slow) &&
                            (s_next.state != msadc_pkg::st_slow) && (s_reg.cycle == 3'h0);
   end

   // ==========================================================================
   // State register
   // ==========================================================================
   // Reset leaves every analog control inactive except integrator_reset, which is held low until the reset delay ends.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.ctrl.fast_discharge_n <= 1'b1;
         s_reg.ctrl.slow_discharge_n <= 1'b1;
         s_reg.bal_sync <= 2'b11;
         balance_strobe_reg <= 1'b0;
      end else begin
         s_reg <= s_next;
         balance_strobe_reg <= balance_strobe_next;
      end
   end

   // Outputs come straight from the state register; the balance strobe comes from its own register.
   assign ctrl_o = s_reg.ctrl;
   assign result_fast_o = s_reg.result_fast;
   assign result_slow_o = s_reg.result_slow;
   assign result_cycle_o = s_reg.cycle;
   assign conversion_done_o = s_reg.conversion_done;
   assign unbalanced_indication_o = s_reg.unbalanced_indication;
   assign overrange_detect_o = s_reg.overrange_detect;
   assign busy_o = s_reg.busy;
   assign balance_check_strobe_o = balance_strobe_reg;

   // ==========================================================================
   // Assertions
   // ==========================================================================
   sequence sync_pulse;
      ctrl_o.phase_sync [*8];
   endsequence
   a_sync_start: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(ctrl_o.phase_sync) |-> sync_pulse) else $error("sync pulse too short");
   a_first_offset: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(ctrl_o.phase_sync) |-> result_cycle_o == 3'h0) else $error("not offset first");
   a_charge_excl: assert property (@(posedge mclk_i) disable iff (rst_i)
      ctrl_o.charge_enable |-> ctrl_o.fast_discharge_n && ctrl_o.slow_discharge_n)
      else $error("charge overlaps discharge");
   a_fast_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(ctrl_o.charge_enable) && !overrange_detect_o |-> ctrl_o.fast_discharge_n [*8])
      else $error("no hold before fast discharge");
   a_gate_match: assert property (@(posedge mclk_i) disable iff (rst_i)
      !ctrl_o.fast_discharge_n |-> ctrl_o.count_gate) else $error("gate off in fast");
   a_slow_exclusive: assert property (@(posedge mclk_i) disable iff (rst_i)
      !(!ctrl_o.slow_discharge_n && !ctrl_o.fast_discharge_n)) else $error("both discharges");
   a_done_slow: assert property (@(posedge mclk_i) disable iff (rst_i)
      conversion_done_o |-> $rose(ctrl_o.slow_discharge_n)) else $error("done not at slow end");
   a_shift_once: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(ctrl_o.quadrature_shift) |-> result_cycle_o == `SHIFT_CYCLE)
      else $error("shift in wrong cycle");
endmodule
`default_nettype wire

/* File: test_msadc_sequencer.sv */
// Purpose: Self-checking bench for the converter sequencer.
// Assumes: Shortened charge cap, interim and fast minimum through parameters.
// Notes:   One overrange abort, then a full measurement with an unbalanced offset.
`default_nettype none
module test_msadc_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   // ======================================================================
   // Signals
   // ======================================================================
   localparam int unsigned INT_CYC = 200;
   localparam int unsigned FAST_MIN = 2560;
   logic                     mclk_i = 1'b0;
   logic                     rst_i = 1'b1;
   logic                     trigger_i = 1'b0;
   logic [1:0]               mode_i = 2'h0;
   logic                     unbal_cmd = 1'b0;
   logic                     over_cmd = 1'b0;
   msadc_pkg::afe_flags_type flags;
   msadc_pkg::afe_ctrl_type  ctrl, prev, idle_ctrl;
   logic                     strobe, done, unbal, over, busy, prev_busy = 1'b0;
   logic [11:0]              rf;
   logic [6:0]               rs;
   logic [2:0]               rc, last_rc = 3'h0;
   int                       miscompares = 0, check_count = 0;
   int sync_n = 0, fast_n = 0, slow_n = 0, gate_n = 0, busy_n = 0, gap_n = 0;
   int hold_n = 0, shift_n = 0;
   int unsigned              done_q[$];
   msadc_sequencer #(.CHARGE_CYC(2000), .INTERIM_CYC(INT_CYC), .FAST_MIN_CYC(FAST_MIN))
   msadc_sequencer_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .trigger_i(trigger_i), .mode_i(mode_i),
      .flags_i(flags), .balance_check_strobe_o(strobe), .ctrl_o(ctrl),
      .result_fast_o(rf), .result_slow_o(rs), .result_cycle_o(rc),
      .conversion_done_o(done), .unbalanced_indication_o(unbal),
      .overrange_detect_o(over), .busy_o(busy));
   msadc_afe_model msadc_afe_model_i (
      .mclk_i(mclk_i), .rst_i(rst_i), .ctrl_i(ctrl), .unbalanced_i(unbal_cmd),
      .overrange_i(over_cmd), .flags_o(flags));
   initial begin
      forever #10 mclk_i = ~mclk_i;
   end
   // ======================================================================
   // Helpers
   // ======================================================================
   function automatic logic near(int a, int b, int tol);
      return (a - b <= tol) && (b - a <= tol);
   endfunction
   // Total in slow-count units; 4 MHz ticks are 4 of every 50 clocks.
   function automatic int exp_total(int f, int s);
      return (f * 4 / 50) * 128 + s * 4 / 50;
   endfunction
   function automatic int mode_bound(logic [1:0] m);
      return (m == 2'h0) ? 1600000 : (m == 2'h1) ? 6000000 : 51000000;
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic wait_for(input int which, input int lim);
      int n = 0;
      while (n < lim && !((which == 0 && ctrl.charge_enable === 1'b1) ||
             (which == 1 && busy === 1'b0) || (which == 2 && strobe === 1'b1))) begin
         @(posedge mclk_i);
         n++;
      end
      check("wait bound", 32'(n < lim), 32'd1);
   endtask
   task automatic pulse_trigger();
      @(negedge mclk_i) trigger_i = 1'b1;
      @(negedge mclk_i) trigger_i = 0;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ======================================================================
   // Port monitor: times the sync, reset and hold steps, and the interim before vector cycles 2 to 4.
   // ======================================================================
   always @(posedge mclk_i) begin
      sync_n += ctrl.phase_sync;
      fast_n += !ctrl.fast_discharge_n;
      slow_n += !ctrl.slow_discharge_n;
      gate_n += ctrl.count_gate;
      busy_n += busy;
      gap_n++;
      hold_n++;
      if (prev.phase_sync && !ctrl.phase_sync) begin
         check("sync width", 32'(sync_n), 32'd2500);
         sync_n = 0;
         gap_n = 0;
      end
      if (!prev.integrator_reset && ctrl.integrator_reset) begin
         if (done_q.size() == 0) check("reset rise", 32'(near(gap_n, 5000, 2)), 1);
         else check("reset low", 32'(near(gap_n, 25000, 2)), 1);
      end
      if (prev.integrator_reset && !ctrl.integrator_reset) gap_n = 0;
      if (!prev.charge_enable && ctrl.charge_enable) begin
         check("hold pulse", 32'(prev.hold1 ^ prev.hold2), 1);
         check("hold which", 32'(prev.hold1), 32'(done_q.size() == 0));
      end
      if (!prev.charge_enable && ctrl.charge_enable && done_q.size() > 0 && last_rc != 0)
         check("interim", 32'(near(gap_n, INT_CYC + 1000, 3)), 1);
      if (prev.charge_enable && !ctrl.charge_enable && !over_cmd) begin
         check("vector a", 32'(ctrl.vector_select_a), 32'(rc[0]));
         check("vector b", 32'(ctrl.vector_select_b), 32'(rc != 0 && !rc[0]));
         hold_n = 0;
      end
      if (prev.fast_discharge_n && !ctrl.fast_discharge_n)
         check("hold a", 32'(near(hold_n, 1000, 2)), 1);
      if (!prev.fast_discharge_n && ctrl.fast_discharge_n) hold_n = 0;
      if (prev.slow_discharge_n && !ctrl.slow_discharge_n)
         check("hold b", 32'(near(hold_n, 1000, 2)), 1);
      if (!prev.quadrature_shift && ctrl.quadrature_shift) begin
         shift_n++;
         check("shift cycle", 32'(rc), 32'd2);
         check("shift after charge", 32'(ctrl.charge_enable), 0);
      end
      if (strobe) check("strobe cycle", 32'(rc), 32'd0);
      if (done) begin
         check("fast min", 32'(fast_n >= FAST_MIN), 1);
         check("slow ended", 32'(ctrl.slow_discharge_n), 1);
         check("gate span", 32'(near(gate_n, fast_n + slow_n, 4)), 1);
         check("count", 32'(near(rf * 128 + rs, exp_total(fast_n, slow_n), 260)), 1);
         done_q.push_back(rc);
         last_rc = rc;
         fast_n = 0;
         slow_n = 0;
         gate_n = 0;
         gap_n = 0;
      end
      if (prev_busy && !busy) begin
         check("duration", 32'(busy_n < mode_bound(mode_i)), 1);
         busy_n = 0;
      end
      prev = ctrl;
      prev_busy = busy;
   end
   // ======================================================================
   // Tests
   // ======================================================================
   initial begin
      // A vector cycle's index has already advanced when its done pulse shows.
      int unsigned exp_seq[6] = '{0, 0, 2, 3, 4, 5};
      void'($urandom(88));
      repeat (5) @(posedge mclk_i);
      @(negedge mclk_i) rst_i = 1'b0;
      idle_ctrl = '0;
      idle_ctrl.fast_discharge_n = 1'b1;
      idle_ctrl.slow_discharge_n = 1'b1;
      check("idle controls", 32'(ctrl), 32'(idle_ctrl));
      check("idle busy", 32'({busy, done, over, unbal}), 0);
      // Zero-cross inside the first charge aborts the measurement.
      mode_i = 2'($urandom_range(2, 0));
      pulse_trigger();
      wait_for(0, 20000);
      @(negedge mclk_i) over_cmd = 1'b1;
      wait_for(1, 50);
      check("overrange", 32'(over), 1);
      check("charge off", 32'(ctrl.charge_enable), 0);
      @(negedge mclk_i) over_cmd = 1'b0;
      // Full run: offset repeats while the bridge is unbalanced; a late trigger is ignored.
      unbal_cmd = 1'b1;
      pulse_trigger();
      wait_for(2, 100000);
      repeat (10) @(negedge mclk_i);
      unbal_cmd = 1'b0;
      check("unbalanced flag", 32'(unbal), 1);
      pulse_trigger();
      wait_for(1, 100000);
      check("cycle count", done_q.size(), 6);
      for (int i = 0; i < 6 && i < done_q.size(); i++) begin
         check("cycle order", done_q[i], exp_seq[i]);
      end
      check("shift count", 32'(shift_n), 1);
      wrap_up();
   end
   initial begin
      #(20 * 110000);
      miscompares++;
      wrap_up();
   end
endmodule
`default_nettype wire
